//--- core/aapc_pkg.sv
// Shared constants, register map and types for the angle output block
package aapc_pkg;
  // Clock and angle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_PERIOD_US = 25;
  localparam int LATENCY_US = 60;
  localparam int SAMPLE_CYC = (SAMPLE_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATENCY_CYC = (LATENCY_US * 1000) / CLK_PERIOD_NS;
  localparam int SER_BIT_CYC = 100;
  // Widths
  localparam int ANGLE_W = 13;
  localparam int AVG_W = 3;
  localparam int ACC_W = 20;
  localparam int ERR_W = 8;
  localparam int PWM_ANGLE_W = 12;
  // Pulse-width timing
  localparam int PWM_PERIOD_CYC = 4000;
  localparam int PWM_LEAD_PCT = 5;
  localparam int PWM_SPAN_PCT = 90;
  // Supply-line Manchester port
  localparam int MAN_BIT_CYC = 1000;
  localparam int MAN_FRAME_BITS = 16;
  localparam logic [1:0] MAN_KIND_WRITE = 2'h1;
  localparam logic [1:0] MAN_KIND_READ = 2'h2;
  localparam logic [1:0] MAN_KIND_SPECIAL = 2'h3;
  localparam logic [11:0] MAN_ACCESS_CODE = 12'hA5C;
  localparam logic [11:0] MAN_EXIT_CODE = 12'h5A3;
  // Non-volatile image layout
  localparam int NVM_AVG_LSB = 0;
  localparam int NVM_SPEED_BIT = 3;
  localparam int NVM_MAN_DIS_BIT = 18;
  localparam int SUPPLY_DROP_BIT = 0;
  localparam logic [15:0] MASK_RESET = 16'h0001;
  // Register offsets
  localparam logic [7:0] REG_ANGLE = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_ERR = 8'h0C;
  localparam logic [7:0] REG_STAT = 8'h10;
  // Configuration register layout, high bits first
  typedef struct packed {
    logic man_dis;
    logic speed_hi;
    logic [AVG_W-1:0] sample_average_select;
  } aapc_cfg_s;
endpackage : aapc_pkg

//--- core/aapc_pwm.sv
// Pulse-width encoder with tristate on fault
`timescale 1ns/100ps
module aapc_pwm #(
  parameter int PERIOD = aapc_pkg::PWM_PERIOD_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Angle and fault
  input wire logic [aapc_pkg::ANGLE_W-1:0] angle_i,
  input wire logic fault_i,
  // Pin
  output logic pwm_o,
  output logic pwm_oe_n_o
);
  localparam int LEAD = (PERIOD * aapc_pkg::PWM_LEAD_PCT + 99) / 100;
  localparam int SPAN = (PERIOD * aapc_pkg::PWM_SPAN_PCT) / 100;

  logic [31:0] cnt_r;
  logic [aapc_pkg::PWM_ANGLE_W-1:0] lat_r;
  logic [31:0] high_cyc;

  // Lead-in plus angle share of the span; never reaches the full period
  assign high_cyc = 32'(LEAD) + ((32'(SPAN) * {20'h00000, lat_r}) >> aapc_pkg::PWM_ANGLE_W);

  // Period counter, angle taken once at each period start
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt_r <= 32'h0;
      lat_r <= '0;
    end else if (cnt_r == 32'(PERIOD - 1)) begin
      cnt_r <= 32'h0;
      lat_r <= angle_i[aapc_pkg::ANGLE_W-1:1];
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // Output level and enable; fault releases the pin
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pwm_o <= 1'b0;
      pwm_oe_n_o <= 1'b1;
    end else begin
      pwm_o <= !fault_i && (cnt_r < high_cyc);
      pwm_oe_n_o <= fault_i;
    end
  end
endmodule : aapc_pwm

//--- core/aapc_angle_out.sv
// Angle averaging, publication, serial and pulse-width output, supply-line command port
`timescale 1ns/100ps
module aapc_angle_out #(
  parameter int SAMPLE_CYC = aapc_pkg::SAMPLE_CYC,
  parameter int LAT_CYC = aapc_pkg::LATENCY_CYC,
  parameter int PWM_PERIOD = aapc_pkg::PWM_PERIOD_CYC,
  parameter int MAN_BIT = aapc_pkg::MAN_BIT_CYC,
  parameter int SER_BIT = aapc_pkg::SER_BIT_CYC
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  // Front-end samples
  output logic sample_tick_o,
  input wire logic [aapc_pkg::ANGLE_W-1:0] sample_angle_i,
  // Non-volatile image
  input wire logic [31:0] nvm_cfg_word_i,
  input wire logic [15:0] nvm_mask_word_i,
  // Error flags
  input wire logic [aapc_pkg::ERR_W-1:0] err_primary_i,
  input wire logic [aapc_pkg::ERR_W-1:0] error_status_secondary_i,
  // Pins
  input wire logic die_addr_bit0_i,
  input wire logic die_addr_bit1_i,
  input wire logic supply_man_i,
  input wire logic man_tx_i,
  output logic ser_o,
  output logic pwm_o,
  output logic pwm_oe_n_o,
  // Internal angle output and command port
  output logic [aapc_pkg::ANGLE_W-1:0] angle_o,
  output logic angle_update_o,
  output logic man_mode_o,
  output logic cmd_valid_o,
  output logic [aapc_pkg::MAN_FRAME_BITS-1:0] cmd_frame_o
);
  localparam int DLY_N = LAT_CYC / SAMPLE_CYC;
  localparam int DLY_OFS = LAT_CYC % SAMPLE_CYC;
  localparam int DLY_IDX = (DLY_OFS == 0) ? DLY_N - 1 : DLY_N;
  localparam int WIN_LO = (MAN_BIT * 3) / 4;
  localparam int WIN_HI = (MAN_BIT * 5) / 4;
  localparam int AW = aapc_pkg::ANGLE_W;
  localparam int FB = aapc_pkg::MAN_FRAME_BITS;

  typedef enum logic {AAPC_MAN_IDLE, AAPC_MAN_RUN} aapc_man_e;

  aapc_pkg::aapc_cfg_s cfg_r;
  logic [15:0] mask_r;
  logic init_r;
  logic [15:0] div_r;
  logic [AW-1:0] dly_r [0:DLY_N];
  logic [DLY_N:0] dly_v_r;
  logic pub_ev;
  logic [AW-1:0] pub_smp;
  logic [aapc_pkg::AVG_W-1:0] n_log;
  logic [aapc_pkg::ACC_W-1:0] acc_r;
  logic [aapc_pkg::ACC_W-1:0] acc_nxt;
  logic [7:0] cnt_r;
  logic [AW-1:0] angle_r;
  logic upd_r;
  logic fault;
  logic [1:0] addr_s1_r;
  logic [1:0] addr_s2_r;
  logic man_s1_r;
  logic man_s2_r;
  logic man_s3_r;
  logic tx_s1_r;
  logic tx_s2_r;
  logic man_edge;
  aapc_man_e man_st_r;
  logic [15:0] man_tmr_r;
  logic [FB-1:0] man_sh_r;
  logic [5:0] man_cnt_r;
  logic frame_end;
  logic addr_ok;
  logic enter_ev;
  logic exit_ev;
  logic man_mode_r;
  logic cmd_valid_r;
  logic [FB-1:0] cmd_frame_r;
  logic [AW-1:0] ser_sh_r;
  logic [3:0] ser_cnt_r;
  logic [15:0] ser_div_r;
  logic ser_r;
  logic [31:0] rdata_r;

  // Defaults on reset, then one load from the non-volatile image, then software
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cfg_r <= '0;
      mask_r <= aapc_pkg::MASK_RESET;
      init_r <= 1'b0;
    end else if (!init_r) begin
      cfg_r.sample_average_select <= nvm_cfg_word_i[aapc_pkg::NVM_AVG_LSB +: aapc_pkg::AVG_W];
      cfg_r.speed_hi <= nvm_cfg_word_i[aapc_pkg::NVM_SPEED_BIT];
      cfg_r.man_dis <= nvm_cfg_word_i[aapc_pkg::NVM_MAN_DIS_BIT];
      mask_r <= nvm_mask_word_i;
      init_r <= 1'b1;
    end else if (reg_we_i) begin
      if (reg_addr_i == aapc_pkg::REG_CFG) begin
        cfg_r <= reg_wdata_i[$bits(aapc_pkg::aapc_cfg_s)-1:0];
      end
      if (reg_addr_i == aapc_pkg::REG_MASK) begin
        mask_r <= reg_wdata_i[15:0];
      end
    end
  end

  // Sample cadence divider; tick requests a raw sample every period
  always_ff @(posedge core_clk_i) begin
    if (reset_i || div_r == 16'(SAMPLE_CYC - 1)) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end
  assign sample_tick_o = !reset_i && (div_r == 16'h0000);

  // Delay line ageing samples to the fixed response latency
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      dly_v_r <= '0;
    end else if (sample_tick_o) begin
      dly_v_r <= {dly_v_r[DLY_N-1:0], 1'b1};
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (sample_tick_o) begin
      dly_r[0] <= sample_angle_i;
    end
  end
  for (genvar i = 1; i <= DLY_N; i++) begin : g_dly
    always_ff @(posedge core_clk_i) begin
      if (sample_tick_o) begin
        dly_r[i] <= dly_r[i-1];
      end
    end
  end
  assign pub_ev = (div_r == 16'(DLY_OFS)) && dly_v_r[DLY_IDX];
  assign pub_smp = dly_r[DLY_IDX];

  // Averaging depth: high-speed mode forces a single sample
  assign n_log = cfg_r.speed_hi ? '0 : cfg_r.sample_average_select;
  assign acc_nxt = acc_r + {{(aapc_pkg::ACC_W-AW){1'b0}}, pub_smp};

  // Accumulate 2^n samples, publish the shifted sum with a strobe
  always_ff @(posedge core_clk_i) begin
    if (reset_i || (reg_we_i && reg_addr_i == aapc_pkg::REG_CFG)) begin
      acc_r <= '0;
      cnt_r <= 8'h00;
    end else if (pub_ev) begin
      if (cnt_r == 8'((1 << n_log) - 1)) begin
        acc_r <= '0;
        cnt_r <= 8'h00;
      end else begin
        acc_r <= acc_nxt;
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      angle_r <= '0;
      upd_r <= 1'b0;
    end else begin
      upd_r <= 1'b0;
      if (pub_ev && cnt_r == 8'((1 << n_log) - 1)) begin
        angle_r <= AW'(acc_nxt >> n_log);
        upd_r <= 1'b1;
      end
    end
  end
  assign angle_o = angle_r;
  assign angle_update_o = upd_r;

  // Pulse-width output, released on any unmasked error
  assign fault = |({error_status_secondary_i, err_primary_i} & ~mask_r);
  aapc_pwm #(
    .PERIOD(PWM_PERIOD)
  ) u_pwm (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .angle_i(angle_r),
    .fault_i(fault),
    .pwm_o(pwm_o),
    .pwm_oe_n_o(pwm_oe_n_o)
  );

  // Pin synchronisers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      addr_s1_r <= 2'h0;
      addr_s2_r <= 2'h0;
      man_s1_r <= 1'b0;
      man_s2_r <= 1'b0;
      man_s3_r <= 1'b0;
      tx_s1_r <= 1'b1;
      tx_s2_r <= 1'b1;
    end else begin
      addr_s1_r <= {die_addr_bit1_i, die_addr_bit0_i};
      addr_s2_r <= addr_s1_r;
      man_s1_r <= supply_man_i;
      man_s2_r <= man_s1_r;
      man_s3_r <= man_s2_r;
      tx_s1_r <= man_tx_i;
      tx_s2_r <= tx_s1_r;
    end
  end
  assign man_edge = (man_s2_r ^ man_s3_r) && !cfg_r.man_dis && init_r;

  // Manchester receiver: mid-bit edges inside the window carry bits
  assign frame_end = (man_st_r == AAPC_MAN_RUN) && (man_tmr_r > 16'(WIN_HI));
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      man_st_r <= AAPC_MAN_IDLE;
      man_tmr_r <= 16'h0000;
      man_sh_r <= '0;
      man_cnt_r <= 6'h00;
    end else begin
      case (man_st_r)
        AAPC_MAN_IDLE: begin
          man_tmr_r <= 16'h0000;
          if (man_edge) begin
            man_sh_r <= {man_sh_r[FB-2:0], !man_s2_r};
            man_cnt_r <= 6'h01;
            man_st_r <= AAPC_MAN_RUN;
          end
        end
        AAPC_MAN_RUN: begin
          if (frame_end) begin
            man_st_r <= AAPC_MAN_IDLE;
          end else if (man_edge && man_tmr_r >= 16'(WIN_LO)) begin
            man_sh_r <= {man_sh_r[FB-2:0], !man_s2_r};
            man_tmr_r <= 16'h0000;
            if (man_cnt_r != 6'h3F) begin
              man_cnt_r <= man_cnt_r + 6'h01;
            end
          end else begin
            man_tmr_r <= man_tmr_r + 16'h0001;
          end
        end
        default: begin
          man_st_r <= AAPC_MAN_IDLE;
        end
      endcase
    end
  end

  // Frame decode: die address field then kind and payload
  assign addr_ok = frame_end && (man_cnt_r == 6'(FB)) && (man_sh_r[FB-1 -: 2] == addr_s2_r);
  assign enter_ev = addr_ok && man_sh_r[13:12] == aapc_pkg::MAN_KIND_SPECIAL
                    && man_sh_r[11:0] == aapc_pkg::MAN_ACCESS_CODE;
  assign exit_ev = addr_ok && man_mode_r && man_sh_r[13:12] == aapc_pkg::MAN_KIND_SPECIAL
                   && man_sh_r[11:0] == aapc_pkg::MAN_EXIT_CODE;

  // Command mode flag and command hand-off
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      man_mode_r <= 1'b0;
      cmd_valid_r <= 1'b0;
      cmd_frame_r <= '0;
    end else begin
      cmd_valid_r <= 1'b0;
      if (enter_ev) begin
        man_mode_r <= 1'b1;
      end else if (exit_ev) begin
        man_mode_r <= 1'b0;
      end
      if (addr_ok && man_mode_r && (man_sh_r[13:12] == aapc_pkg::MAN_KIND_WRITE
                                    || man_sh_r[13:12] == aapc_pkg::MAN_KIND_READ)) begin
        cmd_valid_r <= 1'b1;
        cmd_frame_r <= man_sh_r;
      end
    end
  end
  assign man_mode_o = man_mode_r;
  assign cmd_valid_o = cmd_valid_r;
  assign cmd_frame_o = cmd_frame_r;

  // Serial angle shifter, one word per update, cut off by command mode
  always_ff @(posedge core_clk_i) begin
    if (reset_i || man_mode_r || enter_ev) begin
      ser_cnt_r <= 4'h0;
      ser_div_r <= 16'h0000;
      ser_sh_r <= '0;
    end else if (upd_r) begin
      ser_sh_r <= angle_r;
      ser_cnt_r <= 4'(AW);
      ser_div_r <= 16'h0000;
    end else if (ser_cnt_r != 4'h0) begin
      if (ser_div_r == 16'(SER_BIT - 1)) begin
        ser_div_r <= 16'h0000;
        ser_sh_r <= {ser_sh_r[AW-2:0], 1'b0};
        ser_cnt_r <= ser_cnt_r - 4'h1;
      end else begin
        ser_div_r <= ser_div_r + 16'h0001;
      end
    end
  end

  // Serial pin: responses in command mode, angle bits otherwise, idle high
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ser_r <= 1'b1;
    end else if (man_mode_r) begin
      ser_r <= tx_s2_r;
    end else begin
      ser_r <= (ser_cnt_r != 4'h0) ? ser_sh_r[AW-1] : 1'b1;
    end
  end
  assign ser_o = ser_r;

  // Register read, answer in the following cycle only
  always_ff @(posedge core_clk_i) begin
    if (reset_i || !reg_re_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      case (reg_addr_i)
        aapc_pkg::REG_ANGLE: rdata_r <= {19'h00000, angle_r};
        aapc_pkg::REG_CFG: rdata_r <= {27'h0000000, cfg_r};
        aapc_pkg::REG_MASK: rdata_r <= {16'h0000, mask_r};
        aapc_pkg::REG_ERR: rdata_r <= {16'h0000, error_status_secondary_i, err_primary_i};
        aapc_pkg::REG_STAT: rdata_r <= {27'h0000000, fault, addr_s2_r, man_mode_r, init_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign reg_rdata_o = rdata_r;
endmodule : aapc_angle_out

//--- verification/aapc_host_model.sv
// Host-side model: Manchester command sender and response bit source
`timescale 1ns/100ps
module aapc_host_model #(
  parameter int MAN_BIT = 40
) (
  // Clock
  input wire logic core_clk_i,
  // Supply line and response source
  output logic supply_man_o,
  output logic man_tx_o
);
  initial begin
    supply_man_o = 1'b0;
    man_tx_o = 1'b1;
  end
  // Response source toggles every cycle so a stale copy never passes
  always @(posedge core_clk_i) begin
    man_tx_o <= ~man_tx_o;
  end
  // One 16-bit frame MSB first; idle at the first half level so no stray edge
  task automatic send(input logic [15:0] f);
    supply_man_o <= f[15];
    repeat (2 * MAN_BIT) @(posedge core_clk_i);
    for (int k = 15; k >= 0; k--) begin
      supply_man_o <= f[k];
      repeat (MAN_BIT / 2) @(posedge core_clk_i);
      supply_man_o <= ~f[k];
      repeat (MAN_BIT / 2) @(posedge core_clk_i);
    end
    repeat (2 * MAN_BIT) @(posedge core_clk_i);
  endtask : send
endmodule : aapc_host_model

//--- verification/aapc_angle_out_props.sv
// Port-level property checker for the angle output block
`timescale 1ns/100ps
module aapc_angle_out_props #(
  parameter int SAMPLE_CYC = 25,
  parameter int LAT_CYC = 60,
  parameter int PWM_PERIOD = 40
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Watched ports
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic sample_tick_o,
  input wire logic [15:0] nvm_mask_word_i,
  input wire logic [aapc_pkg::ERR_W-1:0] err_primary_i,
  input wire logic [aapc_pkg::ERR_W-1:0] error_status_secondary_i,
  input wire logic pwm_o,
  input wire logic pwm_oe_n_o,
  input wire logic [aapc_pkg::ANGLE_W-1:0] angle_o,
  input wire logic angle_update_o,
  input wire logic man_mode_o,
  input wire logic cmd_valid_o
);
  localparam int UPD_LAG = LAT_CYC + 1;
  localparam int TICK_REST = SAMPLE_CYC - 8;
  localparam int LOW_MAX = PWM_PERIOD - 2;
  logic fault;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Unmasked fault as the mask image defines it
  assign fault = |({error_status_secondary_i, err_primary_i} & ~nvm_mask_word_i);
  sequence s_fault_held;
    fault [*3];
  endsequence
  sequence s_lead;
    (pwm_o || pwm_oe_n_o) [*2];
  endsequence
  sequence s_tick_gap;
    (!sample_tick_o) [*8] ##TICK_REST sample_tick_o;
  endsequence
  a_rdata_quiet: assert property (reg_rdata_o != 32'h0 |-> $past(reg_re_i))
    else $error("read data outside a read slot");
  a_read_angle_word: assert property ($past(reg_re_i) && $past(reg_addr_i) == aapc_pkg::REG_ANGLE |->
    reg_rdata_o == {19'h0, $past(angle_o)})
    else $error("angle read differs from published angle");
  a_upd_one_cycle: assert property (angle_update_o |=> !angle_update_o)
    else $error("update strobe longer than one cycle");
  a_angle_hold: assert property (angle_o != $past(angle_o) |-> angle_update_o)
    else $error("angle changed without update strobe");
  a_upd_latency: assert property (angle_update_o |-> $past(sample_tick_o, UPD_LAG))
    else $error("update not at fixed latency after a sample");
  a_tick_period: assert property (sample_tick_o |=> s_tick_gap)
    else $error("sample tick spacing wrong");
  a_fault_tristate: assert property (s_fault_held |=> pwm_oe_n_o && !pwm_o)
    else $error("pulse pin driven during unmasked fault");
  a_pwm_lead: assert property ($rose(pwm_o) && !$past(pwm_oe_n_o) |-> s_lead)
    else $error("lead-in high shorter than expected");
  a_pwm_low_min: assert property ($fell(pwm_o) && !pwm_oe_n_o |-> (!pwm_o) [*3])
    else $error("low time below the full-scale minimum");
  a_pwm_low_max: assert property ($fell(pwm_o) && !pwm_oe_n_o |-> ##[1:LOW_MAX] (pwm_o || pwm_oe_n_o))
    else $error("pulse pin stuck low while driving");
  a_cmd_in_mode: assert property (cmd_valid_o |-> man_mode_o && $past(man_mode_o))
    else $error("command accepted outside command mode");
endmodule : aapc_angle_out_props
bind aapc_angle_out aapc_angle_out_props #(
  .SAMPLE_CYC(SAMPLE_CYC),
  .LAT_CYC(LAT_CYC),
  .PWM_PERIOD(PWM_PERIOD)
) i_aapc_angle_out_props (.core_clk_i, .reset_i, .reg_addr_i, .reg_re_i, .reg_rdata_o, .sample_tick_o,
  .nvm_mask_word_i, .err_primary_i, .error_status_secondary_i, .pwm_o, .pwm_oe_n_o, .angle_o,
  .angle_update_o, .man_mode_o, .cmd_valid_o);

//--- verification/tb_aapc_angle_out.sv
// Self-checking testbench for the angle output block
`timescale 1ns/100ps
module tb_aapc_angle_out;
  localparam int SC = 25;
  localparam int LAT = 60;
  localparam int PP = 40;
  localparam int MB = 40;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [12:0] sample_angle_i = 13'h0;
  logic [31:0] nvm_cfg_word_i = 32'h0000000B;
  logic [15:0] nvm_mask_word_i = aapc_pkg::MASK_RESET;
  logic [7:0] err_primary_i = 8'h00;
  logic [7:0] error_status_secondary_i = 8'h00;
  logic die_addr_bit0_i = 1'b0;
  logic die_addr_bit1_i = 1'b1;
  logic supply_man_i, man_tx_i, ser_o, pwm_o, pwm_oe_n_o, sample_tick_o, angle_update_o, man_mode_o, cmd_valid_o;
  logic [31:0] reg_rdata_o;
  logic [12:0] angle_o, last_ang;
  logic [15:0] cmd_frame_o, fr;
  logic rd_pend = 1'b0;
  int n_mismatch = 0, n_checks = 0, seed = 32'hBD31, cyc = 0, hs = 1, sample_average_select = 3, acc = 0, cnt = 0, hi;
  logic [31:0] q_rd[$];
  logic [15:0] q_cmd[$];
  logic [12:0] q_ang[$];
  int q_cyc[$];
  logic [12:0] q_smp[$];
  int q_tick[$];
  int ser_k = 60;
  logic [12:0] ser_word = 13'h0;
  logic mm_d = 1'b0;
  logic [2:0] tx_h = 3'h0;
  aapc_angle_out #(.SAMPLE_CYC(SC), .LAT_CYC(LAT), .PWM_PERIOD(PP), .MAN_BIT(MB), .SER_BIT(4)) i_aapc_angle_out (
    .core_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .sample_tick_o,
    .sample_angle_i, .nvm_cfg_word_i, .nvm_mask_word_i, .err_primary_i, .error_status_secondary_i,
    .die_addr_bit0_i, .die_addr_bit1_i, .supply_man_i, .man_tx_i, .ser_o, .pwm_o, .pwm_oe_n_o, .angle_o,
    .angle_update_o, .man_mode_o, .cmd_valid_o, .cmd_frame_o);
  aapc_host_model #(.MAN_BIT(MB)) i_aapc_host_model (.core_clk_i, .supply_man_o(supply_man_i), .man_tx_o(man_tx_i));
  // Clock
  initial forever #5 core_clk_i = ~core_clk_i;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge core_clk_i);
    reg_we_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : wr
  // Register read; expected word queued for the watcher
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    q_rd.push_back(exp);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge core_clk_i);
    reg_re_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : rd
  // Sample source: fresh angle every cycle; a sample joins its group once its latency has run out
  always @(posedge core_clk_i) begin
    if (sample_tick_o && !reset_i) begin
      q_smp.push_back(sample_angle_i);
      q_tick.push_back(cyc);
    end
    if (q_tick.size() > 0 && q_tick[0] == cyc - LAT) begin
      acc = acc + int'(q_smp.pop_front());
      cnt = cnt + 1;
      if (cnt == (1 << (hs ? 0 : sample_average_select))) begin
        q_ang.push_back(13'(acc >> (hs ? 0 : sample_average_select)));
        q_cyc.push_back(q_tick[0]);
        acc = 0;
        cnt = 0;
      end
      void'(q_tick.pop_front());
    end
    sample_angle_i <= 13'($random(seed));
  end
  // Watcher: compares each result with the oldest note, and cuts a hang short
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (rd_pend) cmp(reg_rdata_o, q_rd.pop_front());
    rd_pend <= reg_re_i;
    if (cmd_valid_o) cmp(32'(cmd_frame_o), 32'(q_cmd.pop_front()));
    if (q_cyc.size() > 0 && q_cyc[0] == cyc - LAT - 1) begin
      void'(q_cyc.pop_front());
      last_ang = q_ang.pop_front();
      cmp(32'(angle_update_o), 32'h1);
      cmp(32'(angle_o), 32'(last_ang));
    end else if (angle_update_o) cmp(32'(angle_update_o), 32'h0);
    // Serial word after each update: bit middles every 4 cycles, then idle high
    if (man_mode_o) ser_k = 60;
    else if (angle_update_o) begin
      ser_word = angle_o;
      ser_k = 0;
    end else if (ser_k < 60) ser_k++;
    if (ser_k % 4 == 3 && ser_k <= 51) cmp(32'(ser_o), 32'(ser_word[12 - ser_k / 4]));
    if (ser_k == 55) cmp(32'(ser_o), 32'h1);
    // Command mode: pin carries the response source three cycles late
    if (man_mode_o && mm_d) cmp(32'(ser_o), 32'(tx_h[2]));
    mm_d <= man_mode_o;
    tx_h <= {tx_h[1:0], man_tx_i};
    if (cyc == 40000) begin
      n_mismatch++;
      results();
    end
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rd(aapc_pkg::REG_CFG, 32'h0000000B);
    rd(aapc_pkg::REG_MASK, 32'h00000001);
    rd(8'h14, 32'h0);
    wr(aapc_pkg::REG_ANGLE, 32'h00001FFF);
    rd(aapc_pkg::REG_STAT, 32'h00000009);
    repeat (300) @(posedge core_clk_i);
    @(posedge core_clk_i iff angle_update_o);
    @(posedge core_clk_i);
    rd(aapc_pkg::REG_ANGLE, 32'(last_ang));
    $display("registers and high-speed angle done");
    for (int a = 0; a < 8; a++) begin
      @(posedge core_clk_i iff sample_tick_o);
      wr(aapc_pkg::REG_CFG, 32'(a));
      hs = 0;
      sample_average_select = a;
      acc = 0;
      cnt = 0;
      repeat ((2 << a) * SC + LAT + 10) @(posedge core_clk_i);
      $display("averaging setting %0d done", a);
    end
    @(posedge core_clk_i iff angle_update_o);
    repeat (PP) @(posedge core_clk_i);
    @(posedge core_clk_i iff !pwm_o);
    @(posedge core_clk_i iff pwm_o);
    hi = 0;
    while (pwm_o) begin
      hi++;
      @(posedge core_clk_i);
    end
    cmp(32'(hi), 32'(2 + ((36 * int'(last_ang[12:1])) >> 12)));
    error_status_secondary_i <= 8'h01;
    repeat (4) @(posedge core_clk_i);
    cmp(32'({pwm_oe_n_o, pwm_o}), 32'h2);
    rd(aapc_pkg::REG_ERR, 32'h00000100);
    error_status_secondary_i <= 8'h00;
    err_primary_i <= 8'h01;
    repeat (4) @(posedge core_clk_i);
    cmp(32'(pwm_oe_n_o), 32'h0);
    err_primary_i <= 8'h00;
    $display("pulse width and fault done");
    i_aapc_host_model.send({2'b10, 2'h3, aapc_pkg::MAN_EXIT_CODE});
    i_aapc_host_model.send({2'b01, 2'h3, aapc_pkg::MAN_ACCESS_CODE});
    cmp(32'(man_mode_o), 32'h0);
    i_aapc_host_model.send({2'b10, 2'h3, aapc_pkg::MAN_ACCESS_CODE});
    cmp(32'(man_mode_o), 32'h1);
    for (int k = 0; k < 3; k++) begin
      fr = {2'b10, 2'(k), 12'($random(seed))};
      if (k > 0) q_cmd.push_back(fr);
      i_aapc_host_model.send(fr);
    end
    i_aapc_host_model.send({2'b10, 2'h3, aapc_pkg::MAN_EXIT_CODE});
    cmp(32'(man_mode_o), 32'h0);
    @(posedge core_clk_i iff sample_tick_o);
    wr(aapc_pkg::REG_CFG, 32'h00000010);
    sample_average_select = 0;
    acc = 0;
    cnt = 0;
    i_aapc_host_model.send({2'b10, 2'h3, aapc_pkg::MAN_ACCESS_CODE});
    cmp(32'(man_mode_o), 32'h0);
    cmp(32'(q_cmd.size()), 32'h0);
    $display("command port done");
    results();
  end
endmodule : tb_aapc_angle_out
